/* hdl/adcsq_cfg.svh */
// Purpose: Addresses, bit positions, reset values and timing counts of the converter control
// Assumes: 10-bit data-memory address space, 4-bit data words
// Notes:   Included by its bare name; definitions only
`ifndef ADCSQ_CFG_SVH
`define ADCSQ_CFG_SVH

`define ADCSQ_ADDR_W           10
`define ADCSQ_A_CHAN           10'h016
`define ADCSQ_A_RLOW           10'h017
`define ADCSQ_A_RHIGH          10'h018
`define ADCSQ_A_MODE2          10'h01A
`define ADCSQ_A_FLAG0          10'h020
`define ADCSQ_A_FLAG1          10'h021
`define ADCSQ_A_IRQ            10'h022

`define ADCSQ_B_START          2
`define ADCSQ_B_LOFF           2
`define ADCSQ_B_IFLAG          0
`define ADCSQ_B_IMASK          1
`define ADCSQ_B_TSEL           0

`define ADCSQ_CHAN_RST         4'h0
`define ADCSQ_LOFF_RST         1'b0
`define ADCSQ_TSEL_RST         1'b0
`define ADCSQ_IMASK_RST        1'b1
`define ADCSQ_IFLAG_RST        1'b0

// Conversion times in system clock periods
`define ADCSQ_CONV_SHORT_TCYC  34
`define ADCSQ_CONV_LONG_TCYC   67
`define ADCSQ_TCYC_PER_CLK     1
`define ADCSQ_CONV_SHORT_CLKS  (`ADCSQ_CONV_SHORT_TCYC * `ADCSQ_TCYC_PER_CLK)
`define ADCSQ_CONV_LONG_CLKS   (`ADCSQ_CONV_LONG_TCYC * `ADCSQ_TCYC_PER_CLK)

`endif

/* hdl/adcsq_pkg.sv */
// Purpose: Types shared by the converter control
// Assumes: Nothing beyond the cfg header
// Notes:   Referenced with package scope only
package adcsq_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_CONV} adcsq_state_e;
  typedef logic [3:0]  adcsq_nib_t;
  typedef logic [6:0]  adcsq_cnt_t;
endpackage

/* hdl/adcsq_ctrl.sv */
// Purpose: Control of an 8-bit converter: channel code, start flag, timing, result, irq flag
// Assumes: CPU data-memory port with nibble writes and single-bit set/clear; analog side
//          supplies the converted value on the clock, ready at the end of the conversion
// Notes:   Result nibbles are not reset and read undefined until the first conversion
// Operation
// - Four channels: codes 0-3 valid, rest unused
// - Eight channels: adds codes 4-7
// - Twelve channels: adds codes 8-11, 11xx unused
// - Writing one to start flag starts conversion
// - Completion loads result and clears start flag
// - Start flag reads one while converting
// - Writing zero to start flag does nothing
// - Reset and stop mode clear start flag
// - Start flag is bit 2 at 0x020
// - Ladder-off flag bit 2 at 0x021
// - Completion sets interrupt flag same cycle
// - Low-power modes cut ladder, no conversion
// - Interrupt flag cleared only by software or reset
// - Dedicated mask gates interrupt request
// - Time select: 34 or 67 clocks
// - Read-only result nibbles, held, not reset
`timescale 1ns/1ps
`include "adcsq_cfg.svh"

module adcsq_ctrl #(
  parameter int NUM_CHANNELS = 12
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic [`ADCSQ_ADDR_W-1:0]    cpu_addr,
  input  wire logic                        cpu_wr,
  input  wire logic [3:0]                  cpu_wdata,
  input  wire logic                        cpu_bset,
  input  wire logic                        cpu_bclr,
  input  wire logic [1:0]                  cpu_bit,
  input  wire logic                        cpu_rd,
  output logic      [3:0]                  cpu_rdata,
  input  wire logic                        stop_mode,
  input  wire logic                        watch_mode,
  input  wire logic                        subactive_mode,
  input  wire logic [7:0]                  conv_result,
  output logic      [3:0]                  mux_channel,
  output logic                             mux_channel_valid,
  output logic                             ladder_current_on,
  output logic                             conv_active,
  output logic                             irq_req
);

  localparam int NUM_CH_LIMIT = (NUM_CHANNELS > 12) ? 12 : NUM_CHANNELS;

  adcsq_pkg::adcsq_state_e state_q, state_d;
  adcsq_pkg::adcsq_cnt_t   cnt_q, cnt_d;
  adcsq_pkg::adcsq_nib_t   chan_q, chan_d;
  adcsq_pkg::adcsq_nib_t   rdata_q, rdata_d;
  adcsq_pkg::adcsq_nib_t   flag0_new, flag1_new, irq_new, mode2_new, chan_new;
  logic [7:0]              result_q, result_d;
  logic                    loff_q, loff_d;
  logic                    tsel_q, tsel_d;
  logic                    irqf_q, irqf_d;
  logic                    imask_q, imask_d;
  logic                    any_op, low_power, start_req, done;
  logic                    hit_flag0, hit_flag1, hit_irq, hit_mode2, hit_chan;

  // Nibble after a full write or a single-bit set/clear
  function automatic adcsq_pkg::adcsq_nib_t apply_op(
    input adcsq_pkg::adcsq_nib_t old,
    input logic                  wr,
    input logic                  bs,
    input logic                  bc,
    input adcsq_pkg::adcsq_nib_t wdata,
    input logic [1:0]            bit_idx
  );
    adcsq_pkg::adcsq_nib_t mask;
    mask = 4'h1 << bit_idx;
    if (wr)
      apply_op = wdata;
    else if (bs)
      apply_op = old | mask;
    else if (bc)
      apply_op = old & ~mask;
    else
      apply_op = old;
  endfunction

  assign any_op    = cpu_wr | cpu_bset | cpu_bclr;
  assign hit_flag0 = any_op && (cpu_addr == `ADCSQ_A_FLAG0);
  assign hit_flag1 = any_op && (cpu_addr == `ADCSQ_A_FLAG1);
  assign hit_irq   = any_op && (cpu_addr == `ADCSQ_A_IRQ);
  assign hit_mode2 = any_op && (cpu_addr == `ADCSQ_A_MODE2);
  assign hit_chan  = any_op && (cpu_addr == `ADCSQ_A_CHAN);
  assign low_power = stop_mode | watch_mode | subactive_mode;

  always_comb
  begin
    flag0_new = apply_op(conv_active ? 4'h4 : 4'h0, cpu_wr, cpu_bset, cpu_bclr,
                         cpu_wdata, cpu_bit);
    flag1_new = apply_op({1'b0, loff_q, 2'b00}, cpu_wr, cpu_bset, cpu_bclr, cpu_wdata, cpu_bit);
    irq_new   = apply_op({2'b00, imask_q, irqf_q}, cpu_wr, cpu_bset, cpu_bclr,
                         cpu_wdata, cpu_bit);
    mode2_new = apply_op({3'b000, tsel_q}, cpu_wr, cpu_bset, cpu_bclr, cpu_wdata, cpu_bit);
    chan_new  = apply_op(chan_q, cpu_wr, cpu_bset, cpu_bclr, cpu_wdata, cpu_bit);
  end

  // Only a one in the start bit acts; zero writes and clears are dropped
  assign start_req = hit_flag0 && flag0_new[`ADCSQ_B_START];

  // Conversion sequencer
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    done    = 1'b0;
    unique case (state_q)
      adcsq_pkg::ST_IDLE:
      begin
        if (start_req && !low_power)
        begin
          state_d = adcsq_pkg::ST_CONV;
          cnt_d   = tsel_q ? 7'(`ADCSQ_CONV_LONG_CLKS - 1)
                           : 7'(`ADCSQ_CONV_SHORT_CLKS - 1);
        end
      end
      adcsq_pkg::ST_CONV:
      begin
        // Watch and subactive freeze the count; the ladder is off there
        if (stop_mode)
          state_d = adcsq_pkg::ST_IDLE;
        else if (!low_power)
        begin
          if (cnt_q == 7'h00)
          begin
            state_d = adcsq_pkg::ST_IDLE;
            done    = 1'b1;
          end
          else
            cnt_d = cnt_q - 7'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= adcsq_pkg::ST_IDLE;
      cnt_q   <= 7'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign conv_active = (state_q == adcsq_pkg::ST_CONV);

  // Result holds across reset on purpose, so it has no reset branch
  always_comb
  begin
    result_d = done ? conv_result : result_q;
  end

  always_ff @(posedge clk)
  begin
    result_q <= result_d;
  end

  // Control and interrupt bits
  always_comb
  begin
    chan_d  = hit_chan  ? chan_new : chan_q;
    tsel_d  = hit_mode2 ? mode2_new[`ADCSQ_B_TSEL] : tsel_q;
    loff_d  = hit_flag1 ? flag1_new[`ADCSQ_B_LOFF] : loff_q;
    imask_d = hit_irq   ? irq_new[`ADCSQ_B_IMASK] : imask_q;
    // Completion beats a same-cycle software clear
    if (done)
      irqf_d = 1'b1;
    else if (hit_irq)
      irqf_d = irq_new[`ADCSQ_B_IFLAG];
    else
      irqf_d = irqf_q;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chan_q  <= `ADCSQ_CHAN_RST;
      tsel_q  <= `ADCSQ_TSEL_RST;
      loff_q  <= `ADCSQ_LOFF_RST;
      imask_q <= `ADCSQ_IMASK_RST;
      irqf_q  <= `ADCSQ_IFLAG_RST;
    end
    else
    begin
      chan_q  <= chan_d;
      tsel_q  <= tsel_d;
      loff_q  <= loff_d;
      imask_q <= imask_d;
      irqf_q  <= irqf_d;
    end
  end

  // Read port; channel and mode registers are write-only and read zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (cpu_rd)
    begin
      unique case (cpu_addr)
        `ADCSQ_A_RLOW:  rdata_d = result_q[3:0];
        `ADCSQ_A_RHIGH: rdata_d = result_q[7:4];
        `ADCSQ_A_FLAG0: rdata_d = {1'b0, conv_active, 2'b00};
        `ADCSQ_A_FLAG1: rdata_d = {1'b0, loff_q, 2'b00};
        `ADCSQ_A_IRQ:   rdata_d = {2'b00, imask_q, irqf_q};
        default:        rdata_d = 4'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 4'h0;
    else
      rdata_q <= rdata_d;
  end

  assign cpu_rdata = rdata_q;
  assign mux_channel = chan_q;
  // Codes at or above the variant's count are unused
  assign mux_channel_valid = (int'(chan_q) < NUM_CH_LIMIT);
  assign ladder_current_on = !loff_q && !low_power;
  assign irq_req = irqf_q && !imask_q;

  property p_start;
    @(posedge clk) disable iff (!reset_n)
    (!conv_active && start_req && !low_power) |=> conv_active ##0
    (cnt_q == (tsel_q ? 7'd66 : 7'd33));
  endproperty
  a_start: assert property (p_start) else $error("start did not begin timed conversion");

  property p_zero_write;
    @(posedge clk) disable iff (!reset_n)
    (!conv_active && hit_flag0 && !flag0_new[2]) |=> !conv_active;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write started a conversion");

  property p_finish;
    @(posedge clk) disable iff (!reset_n)
    (conv_active && cnt_q == 7'h00 && !low_power) |=>
    (!conv_active && irqf_q && result_q == $past(conv_result));
  endproperty
  a_finish: assert property (p_finish) else $error("completion effects missing");

  property p_irq_same_cycle;
    @(posedge clk) disable iff (!reset_n)
    $fell(conv_active) && !$past(stop_mode) |-> irqf_q;
  endproperty
  a_irq_same_cycle: assert property (p_irq_same_cycle) else $error("irq flag not set");

  property p_stop;
    @(posedge clk) disable iff (!reset_n)
    stop_mode |=> !conv_active;
  endproperty
  a_stop: assert property (p_stop) else $error("stop mode left start flag set");

  property p_ladder;
    @(posedge clk) disable iff (!reset_n)
    ladder_current_on |-> !loff_q && !stop_mode && !watch_mode && !subactive_mode;
  endproperty
  a_ladder: assert property (p_ladder) else $error("ladder current on when it must be off");

  property p_irqf_sticky;
    @(posedge clk) disable iff (!reset_n)
    (irqf_q && !hit_irq) |=> irqf_q;
  endproperty
  a_irqf_sticky: assert property (p_irqf_sticky) else $error("irq flag cleared itself");

  property p_irq_mask;
    @(posedge clk) disable iff (!reset_n)
    irq_req |-> irqf_q && !imask_q;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq forwarded");

  property p_readback;
    @(posedge clk) disable iff (!reset_n)
    (cpu_rd && cpu_addr == `ADCSQ_A_FLAG0) |=> cpu_rdata[2] == $past(conv_active);
  endproperty
  a_readback: assert property (p_readback) else $error("start flag readback wrong");

  property p_chan_valid;
    @(posedge clk) disable iff (!reset_n)
    mux_channel_valid |-> (chan_q < 4'hC) && (NUM_CHANNELS > 4 || chan_q[3:2] == 2'b00)
                          && (NUM_CHANNELS > 8 || !chan_q[3]);
  endproperty
  a_chan_valid: assert property (p_chan_valid) else $error("unused channel marked valid");

endmodule // adcsq_ctrl

/* bench/adcsq_analog_model.sv */
// Purpose: Far side of the converter control: input mux, ladder and comparator
// Assumes: Bench sets the analog level; one conversion value per start
// Notes:   Outside a valid conversion the output churns every cycle
`timescale 1ns/1ps

module adcsq_analog_model (
  input  wire logic       clk,
  input  wire logic [3:0] mux_channel,
  input  wire logic       mux_channel_valid,
  input  wire logic       ladder_current_on,
  input  wire logic       conv_active,
  input  wire logic [7:0] analog_level,
  output logic      [7:0] conv_result
);
  logic [7:0] churn_q = 8'hA5;

  // No stale value may pass for a real conversion
  always @(posedge clk)
  begin
    churn_q <= churn_q + 8'h5B;
  end

  assign conv_result = (conv_active && ladder_current_on && mux_channel_valid) ?
                       analog_level : churn_q ^ {4'h0, mux_channel};
endmodule // adcsq_analog_model

/* bench/tb_top.sv */
// Purpose: Self-checking bench of the converter control
// Assumes: Twelve-channel variant, cfg header addresses
// Notes:   Expected values come from the bench's own reckoning
`timescale 1ns/1ps
`include "adcsq_cfg.svh"

module tb_top;
  logic       clk, reset_n, cpu_wr, cpu_bset, cpu_bclr, cpu_rd;
  logic [9:0] cpu_addr;
  logic [3:0] cpu_wdata, cpu_rdata, mux_channel;
  logic [1:0] cpu_bit;
  logic       stop_mode, watch_mode, subactive_mode;
  logic [7:0] conv_result, analog_level, exp_res;
  logic       mux_channel_valid, ladder_current_on, conv_active, irq_req;
  int         miscompares, checks_done;
  int         seed_v;

  adcsq_ctrl #(.NUM_CHANNELS(12)) i_adcsq_ctrl (
    .clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .cpu_bset(cpu_bset), .cpu_bclr(cpu_bclr), .cpu_bit(cpu_bit),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .stop_mode(stop_mode), .watch_mode(watch_mode),
    .subactive_mode(subactive_mode), .conv_result(conv_result), .mux_channel(mux_channel),
    .mux_channel_valid(mux_channel_valid), .ladder_current_on(ladder_current_on),
    .conv_active(conv_active), .irq_req(irq_req));

  adcsq_analog_model i_adcsq_analog_model (
    .clk(clk), .mux_channel(mux_channel), .mux_channel_valid(mux_channel_valid),
    .ladder_current_on(ladder_current_on), .conv_active(conv_active),
    .analog_level(analog_level), .conv_result(conv_result));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Kind: 0 write, 1 bit set, 2 bit clear, 3 read; bit index is d[1:0]
  task automatic acc(input logic [9:0] a, input int k, input logic [3:0] d);
    @(posedge clk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_bit   <= d[1:0];
    cpu_wr    <= (k == 0);
    cpu_bset  <= (k == 1);
    cpu_bclr  <= (k == 2);
    cpu_rd    <= (k == 3);
    @(posedge clk);
    {cpu_wr, cpu_bset, cpu_bclr, cpu_rd} <= 4'h0;
    #1;
  endtask

  task automatic rd(input string what, input logic [9:0] a, input logic [3:0] exp);
    acc(a, 3, 4'h0);
    chk(what, {4'h0, exp}, {4'h0, cpu_rdata});
  endtask

  // Start by write or bit set, count busy cycles, then fetch the result
  task automatic conv(input int k, input int cyc);
    int n;
    n = 0;
    analog_level <= 8'($urandom);
    acc(`ADCSQ_A_FLAG0, k, (k == 0) ? 4'h4 : 4'h2);
    exp_res = analog_level;
    while (conv_active === 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("conv_cycles", 8'(cyc), 8'(n));
    rd("start_flag_done", `ADCSQ_A_FLAG0, 4'h0);
    rd("result_low", `ADCSQ_A_RLOW, exp_res[3:0]);
    rd("result_high", `ADCSQ_A_RHIGH, exp_res[7:4]);
  endtask

  task automatic final_report;
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #50us;
    miscompares++;
    final_report;
  end

  initial
  begin
    {reset_n, cpu_wr, cpu_bset, cpu_bclr, cpu_rd} = 5'h00;
    {stop_mode, watch_mode, subactive_mode} = 3'h0;
    {cpu_addr, cpu_wdata, cpu_bit, analog_level} = '0;
    miscompares = 0;
    checks_done = 0;
    seed_v = $urandom(32'h63AE);
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd("start_flag_rst", `ADCSQ_A_FLAG0, 4'h0);
    rd("ladder_off_rst", `ADCSQ_A_FLAG1, 4'h0);
    rd("irq_reg_rst", `ADCSQ_A_IRQ, 4'h2);
    chk("channel_rst", 8'h00, {4'h0, mux_channel});
    for (int c = 0; c < 16; c++)
    begin
      acc(`ADCSQ_A_CHAN, 0, 4'(c));
      chk("channel", 8'(c), {4'h0, mux_channel});
      chk("channel_valid", 8'(c < 12), {7'h0, mux_channel_valid});
    end
    acc(`ADCSQ_A_CHAN, 0, 4'hB);
    acc(`ADCSQ_A_FLAG0, 0, 4'h0);
    rd("zero_write", `ADCSQ_A_FLAG0, 4'h0);
    conv(1, 34);
    rd("irq_flag_set", `ADCSQ_A_IRQ, 4'h3);
    chk("irq_masked", 8'h00, {7'h0, irq_req});
    acc(`ADCSQ_A_IRQ, 0, 4'h0);
    acc(`ADCSQ_A_MODE2, 0, 4'h1);
    conv(0, 67);
    chk("irq_open", 8'h01, {7'h0, irq_req});
    rd("irq_flag_held", `ADCSQ_A_IRQ, 4'h1);
    acc(`ADCSQ_A_IRQ, 2, 4'h0);
    chk("irq_cleared", 8'h00, {7'h0, irq_req});
    acc(`ADCSQ_A_FLAG1, 1, 4'h2);
    rd("ladder_off_set", `ADCSQ_A_FLAG1, 4'h4);
    chk("ladder_cut", 8'h00, {7'h0, ladder_current_on});
    acc(`ADCSQ_A_FLAG1, 2, 4'h2);
    chk("ladder_on", 8'h01, {7'h0, ladder_current_on});
    @(posedge clk);
    watch_mode <= 1'b1;
    @(posedge clk);
    #1;
    chk("ladder_watch", 8'h00, {7'h0, ladder_current_on});
    @(posedge clk);
    watch_mode     <= 1'b0;
    subactive_mode <= 1'b1;
    acc(`ADCSQ_A_FLAG0, 1, 4'h2);
    chk("sub_refuse", 8'h00, {7'h0, conv_active});
    chk("ladder_sub", 8'h00, {7'h0, ladder_current_on});
    @(posedge clk);
    subactive_mode <= 1'b0;
    acc(`ADCSQ_A_FLAG0, 1, 4'h2);
    rd("start_flag_busy", `ADCSQ_A_FLAG0, 4'h4);
    @(posedge clk);
    stop_mode <= 1'b1;
    @(posedge clk);
    #1;
    chk("stop_abort", 8'h00, {7'h0, conv_active});
    @(posedge clk);
    stop_mode <= 1'b0;
    rd("result_kept", `ADCSQ_A_RLOW, exp_res[3:0]);
    // Mid-run reset: result must survive, control bits return to reset values
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rd("result_after_rst", `ADCSQ_A_RHIGH, exp_res[7:4]);
    rd("irq_after_rst", `ADCSQ_A_IRQ, 4'h2);
    rd("start_after_rst", `ADCSQ_A_FLAG0, 4'h0);
    chk("channel_after_rst", 8'h00, {4'h0, mux_channel});
    final_report;
  end
endmodule // tb_top
